// [common/ich_consts.vh]
// Purpose: Constants of the bus-condition sequencer: register offsets, field bits, resets
// Assumes: Registers are 8 bits wide, reached on a 2-bit word address
// Notes:   Included by bare name; holds definitions only
`ifndef ICH_CONSTS_VH
`define ICH_CONSTS_VH

// Register word addresses
`define ICH_ADDR_CTRL       2'h0
`define ICH_ADDR_STATUS     2'h1
`define ICH_ADDR_RATE       2'h2
`define ICH_ADDR_BUF        2'h3

// Control register field positions
`define ICH_CTRL_ENABLE     0
`define ICH_CTRL_ACKVAL     1
`define ICH_CTRL_IRQEN      2
`define ICH_CTRL_START      3
`define ICH_CTRL_RESTART    4
`define ICH_CTRL_STOP       5
`define ICH_CTRL_ACK        6

// Status register field positions
`define ICH_STAT_EVENT      0
`define ICH_STAT_COLL       1
`define ICH_STAT_WCLASH     2
`define ICH_STAT_BFULL      3
`define ICH_STAT_STOPDET    4
`define ICH_STAT_STARTDET   5
`define ICH_STAT_ACKSTAT    6
`define ICH_STAT_BUSY       7

// Reset values and the bit count of a byte
`define ICH_RATE_RST        8'h09
`define ICH_BYTE_ZERO       8'h00
`define ICH_BITS_PER_BYTE   4'h8

`endif

// [rtl/ich_cond_seq.v]
// Purpose: Host-side bus-condition sequencer with byte transmit and arbitration
// Assumes: SCL and SDA are open-drain; inputs arrive from outside the clock domain
// Notes:   Rate period is (rate reload + 1) cycles of clk_sys; all pin inputs
//          pass two flip-flops before any logic reads them
//
// The address map and the plain strobed port were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "ich_consts.vh"

// Function
// - Ack sequence: SCL low, SDA shows value
// - Ack: period, release SCL, high, period, done
// - Buffer write during sequence sets clash flag
// - Stop: SDA low, sampled low, count
// - Release SCL, one period later SDA
// - Stop seen sets bit; period later event
// - Reset disables unit, aborts transfer
// - Start/stop bits cleared by reset, disable
// - Busy bus stop raises enabled interrupt
// - Released SDA read low means collision
// - Transmit collision halts, clears full, releases
// - Sequence collision aborts, releases, clears controls
// - After collision, bus stop sets event
// - Next buffer write restarts from bit one
// - Lines low at start: collision, idle
// - Start: SDA high loads; SCL low collides
// - Early SDA low restarts count; SCL low
// - Restart: release, count, SCL, sample SDA
// - Restart: SDA falling early is fine
// - Restart: SCL falling early is collision
// - Restart: SDA low, count, SCL low
// - Counter reloads from rate reload register
module ich_cond_seq (
  input  wire       clk_sys,   // System clock, 40 MHz
  input  wire       rstn,      // Asynchronous reset, active low
  input  wire [1:0] regAddr,   // Register word address
  input  wire [7:0] regWdata,  // Write data
  input  wire       regWr,     // Write strobe
  input  wire       regRd,     // Read strobe
  output reg  [7:0] regRdata,  // Read data, valid the cycle after the strobe
  input  wire       sclIn,     // SCL pin level
  output reg        sclOut,    // SCL driven level, always low
  output reg        sclOe,     // SCL pulled low while high
  input  wire       sdaIn,     // SDA pin level
  output reg        sdaOut,    // SDA driven level, always low
  output reg        sdaOe,     // SDA pulled low while high
  output reg        portIrq    // Port event interrupt, level
);

  // One-hot sequencer states
  localparam [17:0] S_IDLE = 18'h00001;
  localparam [17:0] S_ST1  = 18'h00002;  // Start: SDA high, first count
  localparam [17:0] S_ST2  = 18'h00004;  // Start: SDA low, second count
  localparam [17:0] S_RS1  = 18'h00008;  // Restart: SDA released, count
  localparam [17:0] S_RS2  = 18'h00010;  // Restart: SCL released, wait high
  localparam [17:0] S_RS3  = 18'h00020;  // Restart: both high, count
  localparam [17:0] S_RS4  = 18'h00040;  // Restart: SDA low, count
  localparam [17:0] S_AK1  = 18'h00080;  // Ack: SCL low, count
  localparam [17:0] S_AK2  = 18'h00100;  // Ack: SCL released, wait high
  localparam [17:0] S_AK3  = 18'h00200;  // Ack: SCL high, count
  localparam [17:0] S_SP1  = 18'h00400;  // Stop: SDA low, wait sampled low
  localparam [17:0] S_SP2  = 18'h00800;  // Stop: first count
  localparam [17:0] S_SP3  = 18'h01000;  // Stop: SCL released, count
  localparam [17:0] S_SP4  = 18'h02000;  // Stop: SDA released, wait both high
  localparam [17:0] S_SP5  = 18'h04000;  // Stop: trailing count
  localparam [17:0] S_TXL  = 18'h08000;  // Transmit: SCL low, count
  localparam [17:0] S_TXW  = 18'h10000;  // Transmit: SCL released, wait high
  localparam [17:0] S_TXH  = 18'h20000;  // Transmit: SCL high, count

  // Pin synchronisers; the first stage feeds only the second
  reg        sclMeta;
  reg        sclS;                 // Synchronised SCL
  reg        sdaMeta;
  reg        sdaS;                 // Synchronised SDA
  reg        sclPrev;              // SCL one cycle older
  reg        sdaPrev;              // SDA one cycle older

  // Software-visible state
  reg        enable;               // Unit enable
  reg        ackBitValue;          // Value sent during ack sequence
  reg        irqEnable;            // Port interrupt enable
  reg        startSeqGo;           // Start sequence request
  reg        restartSeqGo;         // Repeated start request
  reg        stopSeqGo;            // Stop sequence request
  reg        ackSeqGo;             // Ack sequence request
  reg        portEventFlag;        // Sticky port event
  reg        collisionFlag;        // Sticky bus collision
  reg        writeClashFlag;       // Sticky write clash
  reg        bufferFullFlag;       // Shift buffer holds unsent data
  reg        stopDet;              // Stop seen last
  reg        startDet;             // Start seen last
  reg        ackStat;              // Ack level the client returned
  reg  [7:0] rateReload;           // Rate reload value
  reg  [7:0] shiftBuffer;          // Byte to transmit

  // Sequencer state
  reg [17:0] state;
  reg  [7:0] rateCounter;          // Rate counter
  reg        rateRun;              // Counter running
  reg  [3:0] bitCnt;               // Bit index within byte, 8 is the ack slot
  reg        lostArb;              // Arbitration lost, watching for stop

  // Rate counter expiry strobe
  wire rateExpire = rateRun && (rateCounter == `ICH_BYTE_ZERO);
  // Bit currently placed on SDA during transmit
  wire txBit = (bitCnt < `ICH_BITS_PER_BYTE) ? shiftBuffer[3'h7 - bitCnt[2:0]] : 1'b1;
  // Bus conditions seen by the monitor
  wire busStop  = sclS && sclPrev && sdaS && !sdaPrev;
  wire busStart = sclS && sclPrev && !sdaS && sdaPrev;
  wire idleNow  = (state == S_IDLE);
  wire anyGo    = startSeqGo || restartSeqGo || stopSeqGo || ackSeqGo;
  wire wrCtrl   = regWr && (regAddr == `ICH_ADDR_CTRL);
  wire wrStat   = regWr && (regAddr == `ICH_ADDR_STATUS);
  wire wrBuf    = regWr && (regAddr == `ICH_ADDR_BUF);

  // Arbitration loss detector, one term per phase
  reg collide;
  always @* begin
    collide = 1'b0;
    case (state)
      S_IDLE: collide = enable && startSeqGo && (!sdaS || !sclS);
      S_ST1:  collide = !sclS && sdaS;
      S_RS2:  collide = sclS && !sdaS;
      S_RS3:  collide = !sclS && sdaS;
      S_AK3:  collide = ackBitValue && !sdaS;
      S_TXH:  collide = (bitCnt < `ICH_BITS_PER_BYTE) && txBit && !sdaS;
      default: collide = 1'b0;
    endcase
  end

  // Two-stage synchronisers plus one history stage
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sclMeta <= 1'b1;
      sclS    <= 1'b1;
      sclPrev <= 1'b1;
      sdaMeta <= 1'b1;
      sdaS    <= 1'b1;
      sdaPrev <= 1'b1;
    end else begin
      sclMeta <= sclIn;
      sclS    <= sclMeta;
      sclPrev <= sclS;
      sdaMeta <= sdaIn;
      sdaS    <= sdaMeta;
      sdaPrev <= sdaS;
    end
  end

  // Register writes, sequencer and flags share one process so each bit has one driver
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      enable         <= 1'b0;
      ackBitValue    <= 1'b0;
      irqEnable      <= 1'b0;
      startSeqGo     <= 1'b0;
      restartSeqGo   <= 1'b0;
      stopSeqGo      <= 1'b0;
      ackSeqGo       <= 1'b0;
      portEventFlag  <= 1'b0;
      collisionFlag  <= 1'b0;
      writeClashFlag <= 1'b0;
      bufferFullFlag <= 1'b0;
      stopDet        <= 1'b0;
      startDet       <= 1'b0;
      ackStat        <= 1'b0;
      rateReload     <= `ICH_RATE_RST;
      shiftBuffer    <= `ICH_BYTE_ZERO;
      state          <= S_IDLE;
      rateCounter    <= `ICH_BYTE_ZERO;
      rateRun        <= 1'b0;
      bitCnt         <= 4'h0;
      lostArb        <= 1'b0;
      sclOe          <= 1'b0;
      sdaOe          <= 1'b0;
    end else begin
      // Software clears come first so a same-cycle hardware set wins
      if (wrStat) begin
        if (regWdata[`ICH_STAT_EVENT])  portEventFlag  <= 1'b0;
        if (regWdata[`ICH_STAT_COLL])   collisionFlag  <= 1'b0;
        if (regWdata[`ICH_STAT_WCLASH]) writeClashFlag <= 1'b0;
      end
      if (wrCtrl) begin
        enable      <= regWdata[`ICH_CTRL_ENABLE];
        ackBitValue <= regWdata[`ICH_CTRL_ACKVAL];
        irqEnable   <= regWdata[`ICH_CTRL_IRQEN];
        // Requests only take effect while nothing else is running
        if (idleNow && !anyGo && regWdata[`ICH_CTRL_ENABLE]) begin
          startSeqGo   <= regWdata[`ICH_CTRL_START];
          restartSeqGo <= regWdata[`ICH_CTRL_RESTART];
          stopSeqGo    <= regWdata[`ICH_CTRL_STOP];
          ackSeqGo     <= regWdata[`ICH_CTRL_ACK];
        end
      end
      if (regWr && (regAddr == `ICH_ADDR_RATE)) rateReload <= regWdata;
      if (wrBuf) begin
        if (idleNow && !anyGo && !bufferFullFlag && enable) begin
          shiftBuffer    <= regWdata;
          bufferFullFlag <= 1'b1;
          bitCnt         <= 4'h0;
          sclOe          <= 1'b1;
          rateCounter    <= rateReload;
          rateRun        <= 1'b1;
          state          <= S_TXL;
        end else begin
          writeClashFlag <= 1'b1;
        end
      end

      // Bus monitor for start and stop conditions
      if (busStart) begin
        startDet <= 1'b1;
        stopDet  <= 1'b0;
      end
      if (busStop) begin
        stopDet  <= 1'b1;
        startDet <= 1'b0;
        lostArb  <= 1'b0;
        if (lostArb || (idleNow && startDet)) portEventFlag <= 1'b1;
      end

      if (rateRun && (rateCounter != `ICH_BYTE_ZERO)) rateCounter <= rateCounter - 8'h01;

      case (state)
        S_IDLE: begin
          // Counter stopped in idle, unless a byte load or a start, restart or ack request starts it now
          if (!wrBuf) rateRun <= 1'b0;
          if (enable && startSeqGo) begin
            sclOe       <= 1'b0;
            sdaOe       <= 1'b0;
            rateCounter <= rateReload;
            rateRun     <= 1'b1;
            state       <= S_ST1;
          end else if (enable && restartSeqGo) begin
            sdaOe       <= 1'b0;
            rateCounter <= rateReload;
            rateRun     <= 1'b1;
            state       <= S_RS1;
          end else if (enable && stopSeqGo) begin
            sdaOe <= 1'b1;
            state <= S_SP1;
          end else if (enable && ackSeqGo) begin
            sclOe       <= 1'b1;
            sdaOe       <= !ackBitValue;
            rateCounter <= rateReload;
            rateRun     <= 1'b1;
            state       <= S_AK1;
          end
        end
        S_ST1: begin
          if (!sdaS || rateExpire) begin
            sdaOe       <= 1'b1;
            rateCounter <= rateReload;
            state       <= S_ST2;
          end
        end
        S_ST2: begin
          if (rateExpire) begin
            sclOe         <= 1'b1;
            startSeqGo    <= 1'b0;
            portEventFlag <= 1'b1;
            state         <= S_IDLE;
          end
        end
        S_RS1: begin
          if (rateExpire) begin
            sclOe   <= 1'b0;
            rateRun <= 1'b0;
            state   <= S_RS2;
          end
        end
        S_RS2: begin
          if (sclS && sdaS) begin
            rateCounter <= rateReload;
            rateRun     <= 1'b1;
            state       <= S_RS3;
          end
        end
        S_RS3: begin
          if (rateExpire) begin
            sdaOe       <= 1'b1;
            rateCounter <= rateReload;
            state       <= S_RS4;
          end
        end
        S_RS4: begin
          if (rateExpire) begin
            sclOe         <= 1'b1;
            restartSeqGo  <= 1'b0;
            portEventFlag <= 1'b1;
            state         <= S_IDLE;
          end
        end
        S_AK1: begin
          if (rateExpire) begin
            sclOe   <= 1'b0;
            rateRun <= 1'b0;
            state   <= S_AK2;
          end
        end
        S_AK2: begin
          // Clock stretching by a client holds us here
          if (sclS) begin
            rateCounter <= rateReload;
            rateRun     <= 1'b1;
            state       <= S_AK3;
          end
        end
        S_AK3: begin
          if (rateExpire) begin
            sclOe         <= 1'b1;
            ackSeqGo      <= 1'b0;
            portEventFlag <= 1'b1;
            state         <= S_IDLE;
          end
        end
        S_SP1: begin
          if (!sdaS) begin
            rateCounter <= rateReload;
            rateRun     <= 1'b1;
            state       <= S_SP2;
          end
        end
        S_SP2: begin
          if (rateExpire) begin
            sclOe       <= 1'b0;
            rateCounter <= rateReload;
            state       <= S_SP3;
          end
        end
        S_SP3: begin
          if (rateExpire) begin
            sdaOe   <= 1'b0;
            rateRun <= 1'b0;
            state   <= S_SP4;
          end
        end
        S_SP4: begin
          if (sdaS && sclS) begin
            stopDet     <= 1'b1;
            startDet    <= 1'b0;
            rateCounter <= rateReload;
            rateRun     <= 1'b1;
            state       <= S_SP5;
          end
        end
        S_SP5: begin
          if (rateExpire) begin
            stopSeqGo     <= 1'b0;
            portEventFlag <= 1'b1;
            state         <= S_IDLE;
          end
        end
        S_TXL: begin
          // Data goes out while SCL is low; slot 8 releases SDA for the ack
          sdaOe <= !txBit;
          if (rateExpire) begin
            sclOe   <= 1'b0;
            rateRun <= 1'b0;
            state   <= S_TXW;
          end
        end
        S_TXW: begin
          if (sclS) begin
            rateCounter <= rateReload;
            rateRun     <= 1'b1;
            state       <= S_TXH;
          end
        end
        S_TXH: begin
          if (rateExpire) begin
            sclOe       <= 1'b1;
            rateCounter <= rateReload;
            if (bitCnt == `ICH_BITS_PER_BYTE) begin
              // Ack slot done: hold SCL low and wait for the next byte
              ackStat       <= sdaS;
              portEventFlag <= 1'b1;
              state         <= S_IDLE;
            end else begin
              if (bitCnt == (`ICH_BITS_PER_BYTE - 4'h1)) bufferFullFlag <= 1'b0;
              bitCnt <= bitCnt + 4'h1;
              state  <= S_TXL;
            end
          end
        end
        default: state <= S_IDLE;
      endcase

      if (collide) begin
        collisionFlag  <= 1'b1;
        lostArb        <= 1'b1;
        bufferFullFlag <= 1'b0;
        startSeqGo     <= 1'b0;
        restartSeqGo   <= 1'b0;
        stopSeqGo      <= 1'b0;
        ackSeqGo       <= 1'b0;
        sclOe          <= 1'b0;
        sdaOe          <= 1'b0;
        rateRun        <= 1'b0;
        state          <= S_IDLE;
      end

      // Disable clears detect bits
      // A write that enables the unit now must keep the requests it carries
      if (!enable && !(wrCtrl && regWdata[`ICH_CTRL_ENABLE])) begin
        startDet       <= 1'b0;
        stopDet        <= 1'b0;
        startSeqGo     <= 1'b0;
        restartSeqGo   <= 1'b0;
        stopSeqGo      <= 1'b0;
        ackSeqGo       <= 1'b0;
        bufferFullFlag <= 1'b0;
        sclOe          <= 1'b0;
        sdaOe          <= 1'b0;
        rateRun        <= 1'b0;
        lostArb        <= 1'b0;
        state          <= S_IDLE;
      end
    end
  end

  // Read port and constant-low pin drivers; read data only in the cycle after the strobe
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      regRdata <= `ICH_BYTE_ZERO;
      sclOut   <= 1'b0;
      sdaOut   <= 1'b0;
      portIrq  <= 1'b0;
    end else begin
      sclOut  <= 1'b0;
      sdaOut  <= 1'b0;
      portIrq <= portEventFlag && irqEnable;
      if (regRd) begin
        case (regAddr)
          `ICH_ADDR_CTRL:   regRdata <= {1'b0, ackSeqGo, stopSeqGo, restartSeqGo,
                                         startSeqGo, irqEnable, ackBitValue, enable};
          `ICH_ADDR_STATUS: regRdata <= {!idleNow, ackStat, startDet, stopDet,
                                         bufferFullFlag, writeClashFlag, collisionFlag,
                                         portEventFlag};
          `ICH_ADDR_RATE:   regRdata <= rateReload;
          default:          regRdata <= shiftBuffer;
        endcase
      end else begin
        regRdata <= `ICH_BYTE_ZERO;
      end
    end
  end

endmodule // ich_cond_seq
`default_nettype wire

// [testbench/ich_bus_model.sv]
// Purpose: Open-drain SCL/SDA bus with pull-ups and a rival host
// Assumes: The rival host pulls a line only when the bench tells it to
// Notes:   Rival SCL runs at 200 ns while fgnRun, then stops once it has released SCL
`timescale 1ns/10ps
`default_nettype none
module ich_bus_model (
  input  wire logic sclOe,    // Host pulls SCL low
  input  wire logic sdaOe,    // Host pulls SDA low
  input  wire logic holdScl,  // Rival pulls SCL low
  input  wire logic holdSda,  // Rival pulls SDA low
  input  wire logic fgnRun,   // Rival clocks SCL
  output var  logic sclLine,  // Wired SCL level
  output var  logic sdaLine   // Wired SDA level
);
  logic fgnScl = 1'b0;  // Rival clock pull
  // Stops only once released, so SCL is left high between frames
  always #100 if (fgnRun || fgnScl) fgnScl = ~fgnScl;
  // Wired-AND; pull-ups give a high level when nobody pulls
  always_comb sclLine = !(sclOe || holdScl || fgnScl);
  always_comb sdaLine = !(sdaOe || holdSda);
endmodule // ich_bus_model
`default_nettype wire

// [testbench/ich_cond_seq_checker.sv]
// Purpose: Port-level checks of the bus-condition sequencer
// Assumes: Rate reload is not rewritten during a sequence
// Notes:   Bound into every ich_cond_seq instance
`timescale 1ns/10ps
`default_nettype none
`include "ich_consts.vh"
module ich_cond_seq_checker (
  input wire logic       clk_sys,
  input wire logic       rstn,
  input wire logic [1:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic       regWr,
  input wire logic       regRd,
  input wire logic [7:0] regRdata,
  input wire logic       sclIn,
  input wire logic       sclOut,
  input wire logic       sclOe,
  input wire logic       sdaIn,
  input wire logic       sdaOut,
  input wire logic       sdaOe,
  input wire logic       portIrq
);
  logic [7:0]  swRate;  // Last rate reload written
  logic        swEn;    // Last enable written
  logic        swIrq;   // Last irq enable written
  logic        seenWr;  // Any write since reset
  logic [15:0] relCnt;  // Cycles since SCL release, saturating
  // Shadows of software state; saturation avoids a wrap after long idle
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      swRate <= `ICH_RATE_RST;
      swEn   <= 1'b0;
      swIrq  <= 1'b0;
      seenWr <= 1'b0;
      relCnt <= 16'h0000;
    end else begin
      seenWr <= seenWr | regWr;
      relCnt <= sclOe ? 16'h0000 : relCnt + {15'h0000, ~&relCnt};
      if (regWr && regAddr == `ICH_ADDR_RATE) swRate <= regWdata;
      if (regWr && regAddr == `ICH_ADDR_CTRL) begin
        swEn  <= regWdata[`ICH_CTRL_ENABLE];
        swIrq <= regWdata[`ICH_CTRL_IRQEN];
      end
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  drive_low_a: assert property (sclOut == 1'b0 && sdaOut == 1'b0)
    else $error("open-drain level driven high");
  rst_release_a: assert property ($rose(rstn) |->
    !sclOe && !sdaOe ##1 !sclOe && !sdaOe)
    else $error("lines held after reset");
  rate_read_a: assert property ($past(regRd) && $past(regAddr) == `ICH_ADDR_RATE
    |-> regRdata == swRate)
    else $error("rate reload reads wrong");
  // Disabled both before and after the edge ahead of the one that sampled the read, so no enabling write
  det_clear_a: assert property ($past(regRd) && $past(regAddr) == `ICH_ADDR_STATUS
    && !$past(swEn) && !$past(swEn, 2) |-> regRdata[5:4] == 2'b00)
    else $error("detect bits kept while disabled");
  irq_gate_a: assert property (portIrq |-> $past(swIrq))
    else $error("interrupt while disabled");
  idle_quiet_a: assert property ($rose(sclOe) || $rose(sdaOe) |-> seenWr)
    else $error("line pulled with no request");
  scl_high_a: assert property ($rose(sclOe) |-> relCnt > {8'h00, swRate})
    else $error("SCL high shorter than a period");
  stop_order_a: assert property ($fell(sdaOe) && !sclOe && !$past(sclOe)
    |-> relCnt > {8'h00, swRate})
    else $error("SDA released too soon after SCL");
endmodule // ich_cond_seq_checker
bind ich_cond_seq ich_cond_seq_checker chk (.clk_sys(clk_sys), .rstn(rstn),
  .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
  .regRdata(regRdata), .sclIn(sclIn), .sclOut(sclOut), .sclOe(sclOe),
  .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .portIrq(portIrq));
`default_nettype wire

// [testbench/test_ich_cond_seq.sv]
// Purpose: Self-checking bench of the bus-condition sequencer
// Assumes: Rate reload 3, so one period is 4 clk_sys cycles
// Notes:   The rival host in the bus model forces each collision
`timescale 1ns/10ps
`default_nettype none
`include "ich_consts.vh"
module test_ich_cond_seq;
  localparam logic [1:0] CTL = `ICH_ADDR_CTRL;
  localparam logic [1:0] STA = `ICH_ADDR_STATUS;
  localparam logic [1:0] RAT = `ICH_ADDR_RATE;
  localparam logic [1:0] BUF = `ICH_ADDR_BUF;
  logic       clk_sys = 1'b0;   // 40 MHz clock
  logic       rstn = 1'b0;      // Reset, active low
  logic [1:0] regAddr = 2'h0;   // Register address
  logic [7:0] regWdata = 8'h00; // Write data
  logic       regWr = 1'b0;     // Write strobe
  logic       regRd = 1'b0;     // Read strobe
  logic       holdScl = 1'b0;   // Rival pulls SCL
  logic       holdSda = 1'b0;   // Rival pulls SDA
  logic       fgnRun = 1'b0;    // Rival clocks SCL
  logic [7:0] q;                // Last read data
  wire  [7:0] regRdata;         // Read data
  wire        sclOe, sdaOe, sclOut, sdaOut, portIrq, sclLine, sdaLine;
  int         miscompares = 0;  // Mismatches
  int         totalChecks = 0;  // Comparisons
  always #12.5 clk_sys = ~clk_sys;
  ich_cond_seq DUT (.clk_sys(clk_sys), .rstn(rstn), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .sclIn(sclLine), .sclOut(sclOut), .sclOe(sclOe), .sdaIn(sdaLine),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .portIrq(portIrq));
  ich_bus_model bus (.sclOe(sclOe), .sdaOe(sdaOe), .holdScl(holdScl),
    .holdSda(holdSda), .fgnRun(fgnRun), .sclLine(sclLine), .sdaLine(sdaLine));
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge clk_sys);
    regWr    <= 1'b0;
  endtask
  // Data stand only in the cycle after the strobe, so sample just past it
  task automatic rd(input logic [1:0] a);
    @(posedge clk_sys);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge clk_sys);
    regRd   <= 1'b0;
    #1 q = regRdata;
  endtask
  task automatic regIs(input logic [1:0] a, input logic [7:0] m, input logic [7:0] e);
    rd(a);
    totalChecks++;
    if ((q & m) !== e) begin
      miscompares++;
      $display("CHECK FAILED reg%0d expected %h seen %h", a, e, q & m);
    end
  endtask
  task automatic pinIs(input string n, input logic [1:0] e, input logic [1:0] g);
    totalChecks++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %b seen %b", n, e, g);
    end
  endtask
  // Polls a control request bit until hardware clears it, bounded
  task automatic waitClr(input logic [7:0] m);
    int n;
    n = 0;
    rd(CTL);
    while ((q & m) != 8'h00 && n < 100) begin
      rd(CTL);
      n++;
    end
  endtask
  task automatic waitScl(input logic v);
    int n;
    n = 0;
    while (sclOe !== v && n < 400) begin
      @(posedge clk_sys);
      #1 n++;
    end
  endtask
  task automatic finishTest();
    $display("Checks %0d, mismatches %0d", totalChecks, miscompares);
    if (miscompares == 0 && totalChecks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Watchdog: the tests need well under 10000 cycles
  initial begin
    #400000;
    miscompares++;
    finishTest();
  end
  initial begin
    wt(20);
    rstn <= 1'b1;
    wt(3);
    regIs(RAT, 8'hFF, `ICH_RATE_RST);
    regIs(STA, 8'h3F, 8'h00);
    regIs(CTL, 8'hFF, 8'h00);
    wr(RAT, 8'h03);
    $display("TEST reset done");
    // Bus idle with both detect bits clear, so claiming it is allowed
    wr(CTL, 8'h0D);
    waitClr(8'h08);
    #1 pinIs("start lines", 2'b11, {sclOe, sdaOe});
    pinIs("irq", 2'b01, {1'b0, portIrq});
    regIs(STA, 8'h07, 8'h01);
    wr(STA, 8'h07);
    $display("TEST start done");
    // Acknowledge, then not-acknowledge, each with a clashing buffer write
    for (int i = 0; i < 2; i++) begin
      wr(CTL, 8'h45 | {6'h00, i[0], 1'b0});
      wt(1);
      #1 pinIs("ack lines", {1'b1, ~i[0]}, {sclOe, sdaOe});
      wr(BUF, 8'hA5);
      waitClr(8'h40);
      // Ack level reports only a transmitted byte, so it stays clear here
      regIs(STA, 8'h46, 8'h04);
      wr(STA, 8'h07);
    end
    $display("TEST ack done");
    wr(CTL, 8'h25);
    waitClr(8'h20);
    regIs(STA, 8'h13, 8'h11);
    #1 pinIs("stop lines", 2'b00, {sclOe, sdaOe});
    wr(STA, 8'h07);
    $display("TEST stop done");
    // Rival holds SCL low before the Start begins
    @(posedge clk_sys) holdScl <= 1'b1;
    wt(4);
    wr(CTL, 8'h09);
    wt(12);
    regIs(STA, 8'h02, 8'h02);
    regIs(CTL, 8'h08, 8'h00);
    #1 pinIs("abort lines", 2'b00, {sclOe, sdaOe});
    @(posedge clk_sys) holdScl <= 1'b0;
    wr(STA, 8'h07);
    $display("TEST start clash done");
    // Rival drives a zero against the first bit, then clocks and stops
    wr(CTL, 8'h09);
    waitClr(8'h08);
    wr(BUF, 8'hFF);
    waitScl(1'b0);
    @(posedge clk_sys) holdSda <= 1'b1;
    wt(12);
    regIs(STA, 8'h0A, 8'h02);
    #1 pinIs("lost lines", 2'b00, {sclOe, sdaOe});
    wr(STA, 8'h07);
    @(posedge clk_sys) fgnRun <= 1'b1;
    wt(40);
    @(posedge clk_sys) fgnRun <= 1'b0;
    wt(16);
    @(posedge clk_sys) holdSda <= 1'b0;
    wt(10);
    regIs(STA, 8'h11, 8'h11);
    wr(STA, 8'h07);
    $display("TEST byte clash done");
    // Stop was seen last, so claiming the bus is allowed
    wr(CTL, 8'h09);
    waitClr(8'h08);
    wr(CTL, 8'h11);
    waitClr(8'h10);
    #1 pinIs("restart lines", 2'b11, {sclOe, sdaOe});
    regIs(STA, 8'h02, 8'h00);
    // Whole byte with nobody answering: the ack slot reads high, buffer empties
    wr(STA, 8'h07);
    wr(BUF, 8'h5A);
    wt(150);
    regIs(STA, 8'hCB, 8'h41);
    @(posedge clk_sys) holdSda <= 1'b1;
    wr(CTL, 8'h11);
    waitClr(8'h10);
    regIs(STA, 8'h02, 8'h02);
    #1 pinIs("restart abort", 2'b00, {sclOe, sdaOe});
    @(posedge clk_sys) holdSda <= 1'b0;
    wr(STA, 8'h07);
    $display("TEST restart done");
    wr(CTL, 8'h09);
    waitClr(8'h08);
    wr(BUF, 8'h7F);
    waitScl(1'b0);
    pinIs("first bit", 2'b01, {sclOe, sdaOe});
    waitScl(1'b1);
    wr(CTL, 8'h00);
    wt(2);
    #1 pinIs("off lines", 2'b00, {sclOe, sdaOe});
    regIs(STA, 8'h30, 8'h00);
    $display("TEST disable done");
    wr(CTL, 8'h09);
    wt(6);
    @(posedge clk_sys) rstn <= 1'b0;
    wt(2);
    #1 pinIs("reset lines", 2'b00, {sclOe, sdaOe});
    @(posedge clk_sys) rstn <= 1'b1;
    wt(2);
    regIs(CTL, 8'hFF, 8'h00);
    $display("TEST reset abort done");
    finishTest();
  end
endmodule // test_ich_cond_seq
`default_nettype wire
